// File: src/itw_map.svh
`ifndef ITW_MAP_SVH
`define ITW_MAP_SVH
// register addresses
`define ITW_ADDR_CTRL      8'h00
`define ITW_ADDR_WAKE      8'h01
`define ITW_ADDR_PULLUP    8'h02
`define ITW_ADDR_STATUS    8'h03
`define ITW_ADDR_MASK      8'h04
`define ITW_ADDR_OSC       8'h05
// control field positions
`define ITW_EDGE_HI        7
`define ITW_EDGE_LO        6
`define ITW_TICK_HI        5
`define ITW_TICK_LO        4
`define ITW_WDT_HI         3
`define ITW_WDT_LO         0
// reset values
`define ITW_CTRL_RESET     8'h8A
`define ITW_WDT_OFF_CODE   4'hA
`define ITW_WDT_ON_CODE    4'h5
// status bits
`define ITW_ST_EXT         0
`define ITW_ST_TICK        1
`define ITW_ST_WAKE        2
`define ITW_ST_WDT         3
// time base: 2^(base+sel) timer clock periods
`define ITW_TICK_BASE_LOG2 10
`define ITW_TICK_CNT_W     13
`endif

// File: src/itw_pkg.sv
package itw_pkg;
	typedef enum logic [1:0] {ITW_EDGE_OFF, ITW_EDGE_RISE, ITW_EDGE_FALL, ITW_EDGE_BOTH} itw_edge_t;
	typedef enum logic [1:0] {ITW_OSC_FAST_XTAL, ITW_OSC_EXT_RC, ITW_OSC_FAST_RC, ITW_OSC_RC_XTAL} itw_osc_t;
	typedef enum logic [1:0] {ITW_RC_4M, ITW_RC_8M, ITW_RC_12M, ITW_RC_RSVD} itw_rcf_t;
endpackage

// File: src/itw_tick.sv
`timescale 1ns/10ps
`include "itw_map.svh"
// time base divider counting timer clock enables
module itw_tick (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// control
	input  wire logic       i_tick_en,
	input  wire logic [1:0] i_sel,
	// event
	output logic            o_tick
);
	typedef struct packed {
		logic [`ITW_TICK_CNT_W-1:0] cnt;
		logic                       tick;
	} itw_tick_st_t;
	itw_tick_st_t st_ff;
	itw_tick_st_t nxt_st;
	logic [`ITW_TICK_CNT_W-1:0] last;

	assign last = (`ITW_TICK_CNT_W'(1) << (`ITW_TICK_BASE_LOG2 + i_sel)) - `ITW_TICK_CNT_W'(1);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (i_tick_en) begin
			if (st_ff.cnt >= last) begin
				nxt_st.cnt = '0;
				nxt_st.tick = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_tick = st_ff.tick;

	a_tick_period: assert property (@(posedge i_clk) disable iff (i_rst)
		o_tick |=> !o_tick)
		else $error("tick repeated back to back");
endmodule

// File: src/itw_ctrl.sv
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "itw_map.svh"
module itw_ctrl (
	// clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	// register port
	input  wire logic [7:0]         i_addr,
	input  wire logic [7:0]         i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic      [7:0]         o_rdata,
	// configuration options
	input  wire logic               i_opt_wdt_always,
	input  wire itw_pkg::itw_osc_t  i_opt_osc,
	input  wire itw_pkg::itw_rcf_t  i_opt_rc_freq,
	// clock sources, halt and watchdog overflow
	input  wire logic               i_sys_tp_en,
	input  wire logic               i_xtal_tp_en,
	input  wire logic               i_pwm_on,
	input  wire logic               i_halted,
	input  wire logic               i_wdt_overflow,
	// pins
	input  wire logic               i_ext_irq_pin,
	input  wire logic [7:0]         i_port_a_pins,
	input  wire logic [7:0]         i_port_a_dir_in,
	// outputs
	output logic                    o_ext_irq,
	output logic                    o_tick,
	output logic                    o_wake,
	output logic                    o_wdt_enable,
	output logic                    o_wdt_reset,
	output logic [7:0]              o_pullup_en,
	output logic                    o_port_a_pin5_io,
	output logic                    o_port_a_pin6_io,
	output logic                    o_xtal_usable,
	output logic [1:0]              o_rc_freq,
	output logic                    o_irq
);
	import itw_pkg::*;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] wake_sel;
		logic [7:0] pull_sel;
		logic [3:0] status;
		logic [3:0] mask;
		logic [7:0] rdata;
		logic [1:0] eirq_s;
		logic [7:0] pa_s1;
		logic [7:0] pa_s2;
		logic [7:0] pa_d;
		logic       eirq_d;
		logic       ext_pulse;
		logic       wake;
		logic       wdt_rst;
	} itw_ctrl_st_t;
	itw_ctrl_st_t st_ff;
	itw_ctrl_st_t nxt_st;

	itw_edge_t  edge_sel;
	logic       tp_en;
	logic       tick;
	logic       eirq_rise;
	logic       eirq_fall;
	logic [7:0] pa_fall;
	logic       halt_wdt;

	assign edge_sel = itw_edge_t'(st_ff.ctrl[`ITW_EDGE_HI:`ITW_EDGE_LO]);
	assign eirq_rise = st_ff.eirq_s[1] & ~st_ff.eirq_d;
	assign eirq_fall = ~st_ff.eirq_s[1] & st_ff.eirq_d;
	assign pa_fall = ~st_ff.pa_s2 & st_ff.pa_d;

	// crystal enables keep arriving while halted
	assign tp_en = i_pwm_on ? (i_sys_tp_en & ~i_halted) : i_xtal_tp_en;

	itw_tick u_tick (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_tick_en (tp_en),
		.i_sel     (st_ff.ctrl[`ITW_TICK_HI:`ITW_TICK_LO]),
		.o_tick    (tick)
	);

	assign halt_wdt = i_wdt_overflow & i_halted & o_wdt_enable;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = 8'h00;
		nxt_st.eirq_s = {st_ff.eirq_s[0], i_ext_irq_pin};
		nxt_st.eirq_d = st_ff.eirq_s[1];
		nxt_st.pa_s1 = i_port_a_pins;
		nxt_st.pa_s2 = st_ff.pa_s1;
		nxt_st.pa_d = st_ff.pa_s2;
		case (edge_sel)
			ITW_EDGE_RISE: nxt_st.ext_pulse = eirq_rise;
			ITW_EDGE_FALL: nxt_st.ext_pulse = eirq_fall;
			ITW_EDGE_BOTH: nxt_st.ext_pulse = eirq_rise | eirq_fall;
			default:       nxt_st.ext_pulse = 1'b0;
		endcase
		// selected falling edge wakes while halted
		nxt_st.wake = i_halted & |(pa_fall & st_ff.wake_sel);
		nxt_st.wdt_rst = halt_wdt;
		if (i_wr) begin
			if (i_addr == `ITW_ADDR_CTRL) begin
				nxt_st.ctrl = i_wdata;
			end else if (i_addr == `ITW_ADDR_WAKE) begin
				nxt_st.wake_sel = i_wdata;
			end else if (i_addr == `ITW_ADDR_PULLUP) begin
				nxt_st.pull_sel = i_wdata;
			end else if (i_addr == `ITW_ADDR_STATUS) begin
				nxt_st.status = st_ff.status & ~i_wdata[3:0];
			end else if (i_addr == `ITW_ADDR_MASK) begin
				nxt_st.mask = i_wdata[3:0];
			end
		end
		// event set wins over clear
		// event flags: tick, external, wake, watchdog
		if (tick) begin
			nxt_st.status[`ITW_ST_TICK] = 1'b1;
		end
		if (st_ff.ext_pulse) begin
			nxt_st.status[`ITW_ST_EXT] = 1'b1;
		end
		if (st_ff.wake) begin
			nxt_st.status[`ITW_ST_WAKE] = 1'b1;
		end
		if (st_ff.wdt_rst) begin
			nxt_st.status[`ITW_ST_WDT] = 1'b1;
		end
		if (i_rd) begin
			if (i_addr == `ITW_ADDR_CTRL) begin
				nxt_st.rdata = st_ff.ctrl;
			end else if (i_addr == `ITW_ADDR_WAKE) begin
				nxt_st.rdata = st_ff.wake_sel;
			end else if (i_addr == `ITW_ADDR_PULLUP) begin
				nxt_st.rdata = st_ff.pull_sel;
			end else if (i_addr == `ITW_ADDR_STATUS) begin
				nxt_st.rdata = {4'h0, st_ff.status};
			end else if (i_addr == `ITW_ADDR_MASK) begin
				nxt_st.rdata = {4'h0, st_ff.mask};
			end else if (i_addr == `ITW_ADDR_OSC) begin
				nxt_st.rdata = {2'b00, o_rc_freq, i_opt_osc, o_port_a_pin6_io,
					o_port_a_pin5_io};
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
			st_ff.ctrl <= `ITW_CTRL_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_wdt_enable = i_opt_wdt_always |
		(st_ff.ctrl[`ITW_WDT_HI:`ITW_WDT_LO] != `ITW_WDT_OFF_CODE);
	assign o_wdt_reset = st_ff.wdt_rst;
	assign o_pullup_en = st_ff.pull_sel & i_port_a_dir_in;
	assign o_port_a_pin5_io = (i_opt_osc == ITW_OSC_EXT_RC) | (i_opt_osc == ITW_OSC_FAST_RC);
	assign o_port_a_pin6_io = (i_opt_osc == ITW_OSC_FAST_RC);
	assign o_xtal_usable = (i_opt_osc == ITW_OSC_RC_XTAL);
	// fixed frequencies, reserved maps to 4 MHz
	assign o_rc_freq = (i_opt_rc_freq == ITW_RC_RSVD) ? 2'd0 : i_opt_rc_freq;
	assign o_ext_irq = st_ff.ext_pulse;
	assign o_tick = tick;
	assign o_wake = st_ff.wake | st_ff.wdt_rst;
	assign o_rdata = st_ff.rdata;
	assign o_irq = |(st_ff.status & st_ff.mask);

	a_wdt_off_code: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_opt_wdt_always && st_ff.ctrl[3:0] == 4'hA) |-> !o_wdt_enable)
		else $error("watchdog enabled under off code");
	a_wdt_always_on: assert property (@(posedge i_clk) disable iff (i_rst)
		i_opt_wdt_always |-> o_wdt_enable)
		else $error("watchdog off despite option");
	a_edge_off: assert property (@(posedge i_clk) disable iff (i_rst)
		(edge_sel == ITW_EDGE_OFF) |=> !st_ff.ext_pulse)
		else $error("edge event while disabled");
	a_tick_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		tick |=> st_ff.status[`ITW_ST_TICK])
		else $error("tick flag not set");
	a_wdt_wake: assert property (@(posedge i_clk) disable iff (i_rst)
		halt_wdt |=> (o_wdt_reset && o_wake))
		else $error("no watchdog reset on halted overflow");
	a_pins_free: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_opt_osc == ITW_OSC_FAST_RC) |-> (o_port_a_pin5_io && o_port_a_pin6_io))
		else $error("pins not released");
	a_ext_rc_pins: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_opt_osc == ITW_OSC_EXT_RC) |-> (o_port_a_pin5_io && !o_port_a_pin6_io))
		else $error("wrong pin use in rc mode");
	a_pullup_in: assert property (@(posedge i_clk) disable iff (i_rst)
		((o_pullup_en & ~i_port_a_dir_in) == 8'h00))
		else $error("pull-up on output pin");

	sequence s_pin_rise;
		st_ff.eirq_s[1] && !st_ff.eirq_d;
	endsequence
	sequence s_pin_fall;
		!st_ff.eirq_s[1] && st_ff.eirq_d;
	endsequence
	a_edge_rise: assert property (@(posedge i_clk) disable iff (i_rst)
		(edge_sel == ITW_EDGE_RISE) ##0 s_pin_rise |=> st_ff.ext_pulse)
		else $error("rising edge missed");
	a_edge_fall: assert property (@(posedge i_clk) disable iff (i_rst)
		(edge_sel == ITW_EDGE_FALL) ##0 s_pin_fall |=> st_ff.ext_pulse)
		else $error("falling edge missed");
	a_edge_both: assert property (@(posedge i_clk) disable iff (i_rst)
		(edge_sel == ITW_EDGE_BOTH) ##0 s_pin_fall |=> st_ff.ext_pulse)
		else $error("edge missed in dual mode");
	a_edge_wrong: assert property (@(posedge i_clk) disable iff (i_rst)
		(edge_sel == ITW_EDGE_RISE) ##0 s_pin_fall |=> !st_ff.ext_pulse)
		else $error("falling edge taken in rising mode");
	sequence s_wake_fall;
		i_halted && |(pa_fall & st_ff.wake_sel);
	endsequence
	a_wake_pin: assert property (@(posedge i_clk) disable iff (i_rst)
		s_wake_fall |=> st_ff.wake)
		else $error("wake pin fall missed");
	a_wake_awake: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_halted |=> !st_ff.wake)
		else $error("wake while running");
	a_wake_needs: assert property (@(posedge i_clk) disable iff (i_rst)
		st_ff.wake |-> $past(i_halted))
		else $error("wake without halt");
	a_wdt_awake: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_halted |=> !o_wdt_reset)
		else $error("watchdog reset while running");
	a_wdt_rst_cond: assert property (@(posedge i_clk) disable iff (i_rst)
		o_wdt_reset |-> $past(halt_wdt))
		else $error("watchdog reset without halted overflow");
	a_wdt_code_on: assert property (@(posedge i_clk) disable iff (i_rst)
		(st_ff.ctrl[`ITW_WDT_HI:`ITW_WDT_LO] != `ITW_WDT_OFF_CODE) |-> o_wdt_enable)
		else $error("watchdog off under enable code");
	a_xtal_pair: assert property (@(posedge i_clk) disable iff (i_rst)
		o_xtal_usable |-> (i_opt_osc == ITW_OSC_RC_XTAL && !o_port_a_pin5_io))
		else $error("crystal usable without fast rc pairing");
	a_rc_fixed: assert property (@(posedge i_clk) disable iff (i_rst)
		o_rc_freq != 2'd3)
		else $error("fast rc frequency out of range");
	a_tick_src_pwm: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_pwm_on && i_halted) |-> !tp_en)
		else $error("system timer clock while halted");
	a_tick_src_xtal: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_pwm_on |-> (tp_en == i_xtal_tp_en))
		else $error("crystal timer clock lost");
	a_status_clear: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wr && i_addr == `ITW_ADDR_STATUS && i_wdata[`ITW_ST_TICK] && !tick)
		|=> !st_ff.status[`ITW_ST_TICK])
		else $error("tick flag not cleared");
	a_pullup_sel: assert property (@(posedge i_clk) disable iff (i_rst)
		((o_pullup_en & ~st_ff.pull_sel) == 8'h00))
		else $error("pull-up on unselected pin");
endmodule

// File: bench/itw_ctrl_tb.sv
`timescale 1ns/10ps
`include "itw_map.svh"
module itw_ctrl_tb;
	import itw_pkg::*;
	logic       i_clk, i_rst, i_wr, i_rd, i_opt_wdt_always, i_sys_tp_en, i_xtal_tp_en;
	logic       i_pwm_on, i_halted, i_wdt_overflow, i_ext_irq_pin;
	logic [7:0] i_addr, i_wdata, i_port_a_pins, i_port_a_dir_in, o_rdata, o_pullup_en;
	itw_osc_t   i_opt_osc;
	itw_rcf_t   i_opt_rc_freq;
	logic       o_ext_irq, o_tick, o_wake, o_wdt_enable, o_wdt_reset, o_irq;
	logic       o_port_a_pin5_io, o_port_a_pin6_io, o_xtal_usable;
	logic [1:0] o_rc_freq;
	int         errors, checks_done, n_ext, n_wake, n_wrst, cyc;

	itw_ctrl u_itw_ctrl (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_opt_wdt_always, .i_opt_osc, .i_opt_rc_freq, .i_sys_tp_en, .i_xtal_tp_en,
		.i_pwm_on, .i_halted, .i_wdt_overflow, .i_ext_irq_pin, .i_port_a_pins,
		.i_port_a_dir_in, .o_ext_irq, .o_tick, .o_wake, .o_wdt_enable, .o_wdt_reset,
		.o_pullup_en, .o_port_a_pin5_io, .o_port_a_pin6_io, .o_xtal_usable, .o_rc_freq,
		.o_irq);

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cyc += 1;
		n_ext += int'(o_ext_irq === 1'b1);
		n_wake += int'(o_wake === 1'b1);
		n_wrst += int'(o_wdt_reset === 1'b1);
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk(o_rdata, exp);
	endtask

	task automatic settle(input logic v, input logic [7:0] p);
		@(posedge i_clk);
		i_ext_irq_pin <= v;
		i_port_a_pins <= p;
		repeat (8) @(posedge i_clk);
	endtask

	task automatic wdt_modes;
		rd(`ITW_ADDR_CTRL, `ITW_CTRL_RESET);
		rd(8'h06, 8'h00);
		wr(8'h06, 8'hFF);
		rd(8'h06, 8'h00);
		@(negedge i_clk) chk(o_wdt_enable, 1'b0);
		wr(`ITW_ADDR_CTRL, 8'h85);
		@(negedge i_clk) chk(o_wdt_enable, 1'b1);
		@(posedge i_clk);
		i_opt_wdt_always <= 1'b1;
		wr(`ITW_ADDR_CTRL, 8'h8A);
		@(negedge i_clk) chk(o_wdt_enable, 1'b1);
		@(posedge i_clk);
		i_opt_wdt_always <= 1'b0;
		@(negedge i_clk) chk(o_wdt_enable, 1'b0);
	endtask

	task automatic edges;
		for (int e = 0; e < 4; e++) begin
			wr(`ITW_ADDR_CTRL, {e[1:0], 6'h05});
			n_ext = 0;
			settle(1'b1, 8'hFF);
			chk(n_ext, e[0]);
			n_ext = 0;
			settle(1'b0, 8'hFF);
			chk(n_ext, e[1]);
		end
	endtask

	task automatic wake;
		wr(`ITW_ADDR_WAKE, 8'h01);
		i_halted <= 1'b1;
		n_wake = 0;
		settle(1'b0, 8'hFD);
		chk(n_wake, 0);
		settle(1'b0, 8'hFC);
		chk(n_wake, 1);
		n_wake = 0;
		i_wdt_overflow <= 1'b1;
		@(posedge i_clk) i_wdt_overflow <= 1'b0;
		repeat (6) @(posedge i_clk);
		chk({n_wake[7:0], n_wrst[7:0]}, 16'h0101);
		i_halted <= 1'b0;
		rd(`ITW_ADDR_STATUS, 8'h0D);
		wr(`ITW_ADDR_STATUS, 8'h0F);
		rd(`ITW_ADDR_STATUS, 8'h00);
	endtask

	task automatic ticks;
		int t0;
		@(posedge i_clk);
		i_pwm_on <= 1'b1;
		i_sys_tp_en <= 1'b1;
		for (int s = 0; s < 5; s++) begin
			// last pass: crystal enables keep the tick going while halted
			if (s == 4) begin
				@(posedge i_clk);
				i_pwm_on <= 1'b0;
				i_xtal_tp_en <= 1'b1;
				i_halted <= 1'b1;
			end
			wr(`ITW_ADDR_CTRL, {2'b00, s[1:0], 4'h5});
			for (int k = 0; k < 2; k++) begin
				t0 = cyc;
				for (int w = 0; w < 9000; w++) begin
					@(negedge i_clk);
					if (o_tick === 1'b1) break;
				end
			end
			chk(cyc - t0, 16'd1024 << s[1:0]);
		end
		rd(`ITW_ADDR_STATUS, 8'h02);
		@(negedge i_clk) chk(o_irq, 1'b0);
		wr(`ITW_ADDR_MASK, 8'h02);
		@(negedge i_clk) chk(o_irq, 1'b1);
		wr(`ITW_ADDR_STATUS, 8'h02);
		@(negedge i_clk) chk(o_irq, 1'b0);
	endtask

	task automatic pins_osc;
		logic [2:0] t[4] = '{3'b000, 3'b100, 3'b110, 3'b001};
		wr(`ITW_ADDR_PULLUP, 8'hF0);
		i_port_a_dir_in <= 8'h3C;
		@(negedge i_clk) chk(o_pullup_en, 8'h30);
		rd(`ITW_ADDR_PULLUP, 8'hF0);
		for (int o = 0; o < 4; o++) begin
			@(posedge i_clk);
			i_opt_osc <= itw_osc_t'(o[1:0]);
			i_opt_rc_freq <= itw_rcf_t'(o[1:0]);
			@(negedge i_clk);
			chk({o_port_a_pin5_io, o_port_a_pin6_io, o_xtal_usable}, t[o]);
			chk(o_rc_freq, o % 3);
			rd(`ITW_ADDR_OSC, {2'b00, 2'(o % 3), o[1:0], t[o][1], t[o][2]});
		end
	endtask

	task automatic conclude;
		if (errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#9000000;
		errors++;
		conclude();
	end

	initial begin
		{i_wr, i_rd, i_opt_wdt_always, i_sys_tp_en, i_xtal_tp_en} = '0;
		{i_pwm_on, i_halted, i_wdt_overflow, i_ext_irq_pin} = '0;
		{i_addr, i_wdata, i_port_a_dir_in} = '0;
		i_port_a_pins = 8'hFF;
		i_opt_osc = ITW_OSC_FAST_XTAL;
		i_opt_rc_freq = ITW_RC_4M;
		{errors, checks_done, n_ext, n_wake, n_wrst, cyc} = '0;
		i_rst = 1'b1;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		wdt_modes();
		edges();
		wake();
		ticks();
		pins_osc();
		conclude();
	end
endmodule
